//--- hdl/rdmac_pkg.sv
// Shared constants, types and helpers of the day/month alarm compare block
package rdmac_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_W  = 4;
    localparam int BYTE_W = 8;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] DAY_ALARM_OFF   = 8'h30;
    localparam logic [7:0] MONTH_ALARM_OFF = 8'h34;
    localparam logic [7:0] CONTROL_OFF     = 8'h38;
    localparam logic [7:0] IRQ_STATUS_OFF  = 8'h3c;
    localparam logic [7:0] IRQ_MASK_OFF    = 8'h40;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int         ENB_BIT          = 7;
    localparam int         RSVD_BIT_SIX     = 6;
    localparam int         RSVD_BIT_FIVE    = 5;
    localparam int         VALUE_W          = 6;
    localparam int         MONTH_CNT_W      = 5;
    localparam int         ALARM_FLAG_BIT   = 0;
    localparam int         AIE_BIT          = 3;
    localparam int         ALARM_EVENT_BIT  = 0;
    localparam int         OTHER_N          = 4;
    localparam logic [5:0] DAY_VALUE_MASK   = 6'h3f;
    localparam logic [5:0] MONTH_VALUE_MASK = 6'h1f;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       enb;
        logic [5:0] value;
    } rdmac_alarm_s;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic regHit(input logic [7:0] adr,
                                    input logic [7:0] off);
        return adr[ADDR_W-1:2] == off[ADDR_W-1:2];
    endfunction : regHit

    function automatic logic fieldOk(input logic       enb,
                                     input logic [5:0] value,
                                     input logic [5:0] counter);
        return !enb || (value == counter);
    endfunction : fieldOk

endpackage : rdmac_pkg

//--- hdl/rdmac_alarm_reg.sv
// One BCD alarm register: value field plus comparison enable
`timescale 1ns/10ps
`default_nettype none
module rdmac_alarm_reg #(
    parameter logic [5:0] VALUE_MASK = rdmac_pkg::DAY_VALUE_MASK
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       writeEn,
    input  wire logic [7:0] writeData,
    output logic      [7:0] readData,
    output logic            enable,
    output logic      [5:0] value
);

    rdmac_pkg::rdmac_alarm_s state;
    rdmac_pkg::rdmac_alarm_s next_state;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (writeEn) begin
            next_state.enb   = writeData[rdmac_pkg::ENB_BIT];
            next_state.value = writeData[rdmac_pkg::VALUE_W-1:0]
                               & VALUE_MASK;
        end
    end

    // ------------------------------------------------------------
    // Register; only enable is cleared, value survives resets
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        state <= next_state;
        if (reset) begin
            state.enb <= 1'b0;
        end
    end

    // Unused bits above the value field always read zero
    assign readData = {state.enb, 1'b0,
                       state.value & VALUE_MASK};
    assign enable   = state.enb;
    assign value    = state.value & VALUE_MASK;

endmodule : rdmac_alarm_reg
`default_nettype wire

//--- hdl/rdmac_match.sv
// Combined alarm match of day, month and the four outside comparators
`timescale 1ns/10ps
`default_nettype none
module rdmac_match (
    input  wire logic       dayEnable,
    input  wire logic [5:0] dayValue,
    input  wire logic [5:0] dayCounter,
    input  wire logic       monthEnable,
    input  wire logic [5:0] monthValue,
    input  wire logic [4:0] monthCounter,
    input  wire logic [3:0] otherEnable,
    input  wire logic [3:0] otherMatch,
    output logic            allMatch,
    output logic            anyEnabled
);

    logic dayOk;
    logic monthOk;

    // BCD digits compare directly, no binary conversion needed
    assign dayOk      = rdmac_pkg::fieldOk(dayEnable, dayValue,
                                           dayCounter);
    assign monthOk    = rdmac_pkg::fieldOk(monthEnable, monthValue,
                                           {1'b0, monthCounter});
    // Disabled registers take no part in the match
    assign allMatch   = dayOk && monthOk
                        && (&(~otherEnable | otherMatch));
    assign anyEnabled = dayEnable || monthEnable || (|otherEnable);

endmodule : rdmac_match
`default_nettype wire

//--- hdl/rdmac_top.sv
// Day/month alarm compare with control flag, interrupt and Wishbone slave
//
// Behaviour
// - The day alarm register is compared with the BCD day counter while its enable is set.
// - The month alarm register is compared with the BCD month counter while its enable is set.
// - The alarm flag sets only when all six enabled alarm registers match; disabled ones are ignored.
// - Power-on reset clears both comparison enables.
// - The value fields keep their contents through every reset and standby.
// - Day alarm bit 7 is the enable, written and read back as stored.
// - Month alarm bit 7 is the enable, written and read back as stored.
// - Month alarm holds units in bits 0 to 3 and tens in bit 4, both read/write.
// - Day alarm bit 6 reads zero and ignores writes.
// - Month alarm bits 5 and 6 read zero and ignore writes.
// - Alarm flag is control bit 0, set on match, cleared by writing 0, unaffected by 1.
// - Control bit 3 lets the flag raise an interrupt; both resets clear it.
`timescale 1ns/10ps
`default_nettype none
module rdmac_top (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        manualReset,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [5:0]  dayCounter,
    input  wire logic [4:0]  monthCounter,
    input  wire logic        counterUpdate,
    input  wire logic [3:0]  otherEnable,
    input  wire logic [3:0]  otherMatch,
    output logic             alarmFlag,
    output logic             irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        ack;
        logic [31:0] datOut;
        logic        alarmFlag;
        logic        aie;
        logic        irqStatus;
        logic        irqMask;
    } rdmac_top_s;

    rdmac_top_s state;
    rdmac_top_s next_state;

    logic       busReq;
    logic       busWrite;
    logic       lane0;
    logic [7:0] wrByte;
    logic       dayWr;
    logic       monthWr;
    logic       ctrlWr;
    logic       statusWr;
    logic       maskWr;
    logic [7:0] dayRead;
    logic [7:0] monthRead;
    logic       dayEnable;
    logic [5:0] dayValue;
    logic       monthEnable;
    logic [5:0] monthValue;
    logic       allMatch;
    logic       anyEnabled;
    logic       matchNow;
    logic [7:0] ctrlRead;
    logic [7:0] readByte;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign busReq   = wb_cyc_i && wb_stb_i;
    // Writes land on the edge that sees ack, matching classic cycles
    assign busWrite = busReq && wb_we_i && state.ack;
    assign lane0    = wb_sel_i[0];
    assign wrByte   = wb_dat_i[rdmac_pkg::BYTE_W-1:0];
    assign dayWr    = busWrite && lane0
                      && rdmac_pkg::regHit(wb_adr_i,
                                           rdmac_pkg::DAY_ALARM_OFF);
    assign monthWr  = busWrite && lane0
                      && rdmac_pkg::regHit(wb_adr_i,
                                           rdmac_pkg::MONTH_ALARM_OFF);
    assign ctrlWr   = busWrite && lane0
                      && rdmac_pkg::regHit(wb_adr_i,
                                           rdmac_pkg::CONTROL_OFF);
    assign statusWr = busWrite && lane0
                      && rdmac_pkg::regHit(wb_adr_i,
                                           rdmac_pkg::IRQ_STATUS_OFF);
    assign maskWr   = busWrite && lane0
                      && rdmac_pkg::regHit(wb_adr_i,
                                           rdmac_pkg::IRQ_MASK_OFF);

    // ------------------------------------------------------------
    // Alarm registers
    // ------------------------------------------------------------
    rdmac_alarm_reg #(
        .VALUE_MASK (rdmac_pkg::DAY_VALUE_MASK)
    ) dayAlarm (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .writeEn    (dayWr),
        .writeData  (wrByte),
        .readData   (dayRead),
        .enable     (dayEnable),
        .value      (dayValue)
    );

    rdmac_alarm_reg #(
        .VALUE_MASK (rdmac_pkg::MONTH_VALUE_MASK)
    ) monthAlarm (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .writeEn    (monthWr),
        .writeData  (wrByte),
        .readData   (monthRead),
        .enable     (monthEnable),
        .value      (monthValue)
    );

    // ------------------------------------------------------------
    // Match
    // ------------------------------------------------------------
    rdmac_match matcher (
        .dayEnable    (dayEnable),
        .dayValue     (dayValue),
        .dayCounter   (dayCounter),
        .monthEnable  (monthEnable),
        .monthValue   (monthValue),
        .monthCounter (monthCounter),
        .otherEnable  (otherEnable),
        .otherMatch   (otherMatch),
        .allMatch     (allMatch),
        .anyEnabled   (anyEnabled)
    );

    // No enabled register means no alarm, not a match every update
    assign matchNow = counterUpdate && anyEnabled
                      && allMatch;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        ctrlRead = 8'h00;
        ctrlRead[rdmac_pkg::ALARM_FLAG_BIT] = state.alarmFlag;
        ctrlRead[rdmac_pkg::AIE_BIT]        = state.aie;
        readByte = 8'h00;
        if (rdmac_pkg::regHit(wb_adr_i, rdmac_pkg::DAY_ALARM_OFF)) begin
            readByte = dayRead;
        end else if (rdmac_pkg::regHit(wb_adr_i,
                                       rdmac_pkg::MONTH_ALARM_OFF)) begin
            readByte = monthRead;
        end else if (rdmac_pkg::regHit(wb_adr_i,
                                       rdmac_pkg::CONTROL_OFF)) begin
            readByte = ctrlRead;
        end else if (rdmac_pkg::regHit(wb_adr_i,
                                       rdmac_pkg::IRQ_STATUS_OFF)) begin
            readByte[rdmac_pkg::ALARM_EVENT_BIT] = state.irqStatus;
        end else if (rdmac_pkg::regHit(wb_adr_i,
                                       rdmac_pkg::IRQ_MASK_OFF)) begin
            readByte[rdmac_pkg::ALARM_EVENT_BIT] = state.irqMask;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state     = state;
        // Ack for exactly one cycle, then drop even if still requested
        next_state.ack = busReq && !state.ack;
        if (busReq && !state.ack) begin
            next_state.datOut = {24'h000000, readByte};
        end
        // Clear first so a same-cycle match still sets the flag
        if (ctrlWr && !wrByte[rdmac_pkg::ALARM_FLAG_BIT]) begin
            next_state.alarmFlag = 1'b0;
        end
        if (matchNow) begin
            next_state.alarmFlag = 1'b1;
        end
        if (ctrlWr) begin
            next_state.aie = wrByte[rdmac_pkg::AIE_BIT];
        end
        if (statusWr && wrByte[rdmac_pkg::ALARM_EVENT_BIT]) begin
            next_state.irqStatus = 1'b0;
        end
        if (matchNow && state.aie) begin
            next_state.irqStatus = 1'b1;
        end
        if (maskWr) begin
            next_state.irqMask = wrByte[rdmac_pkg::ALARM_EVENT_BIT];
        end
    end

    // ------------------------------------------------------------
    // Register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
            if (manualReset) begin
                state.aie <= 1'b0;
                state.ack <= 1'b0;
            end
        end
    end

    assign wb_ack_o  = state.ack;
    assign wb_dat_o  = state.datOut;
    assign alarmFlag = state.alarmFlag;
    assign irq       = state.irqStatus && state.irqMask;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence dayWriteSeq;
        dayWr;
    endsequence

    sequence monthWriteSeq;
        monthWr;
    endsequence

    sequence readAckSeq;
        busReq && !wb_we_i && state.ack;
    endsequence

    enable_clear_a: assert property (@(posedge sys_clk)
        reset |=> !dayEnable && !monthEnable)
        else $error("enable not cleared by reset");

    day_mismatch_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        counterUpdate && dayEnable && dayValue != dayCounter
        && !alarmFlag && !(ctrlWr) |=> !alarmFlag)
        else $error("flag set on day mismatch");

    month_mismatch_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        counterUpdate && monthEnable
        && monthValue != {1'b0, monthCounter}
        && !alarmFlag |=> !alarmFlag)
        else $error("flag set on month mismatch");

    flag_cause_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        $rose(alarmFlag) |-> $past(matchNow))
        else $error("flag rose without a full match");

    // Values are unknown until written; only later resets can be judged
    value_survives_a: assert property (@(posedge sys_clk)
        ((reset && !$past(reset)) || manualReset)
        && !dayWr && !monthWr |=>
        dayValue == $past(dayValue) && monthValue == $past(monthValue))
        else $error("value field lost over reset");

    day_enable_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        dayWriteSeq |=> dayEnable == $past(wrByte[7]))
        else $error("day enable not stored");

    month_enable_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        monthWriteSeq |=> monthEnable == $past(wrByte[7]))
        else $error("month enable not stored");

    month_fields_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        monthWriteSeq |=> monthValue == {1'b0, $past(wrByte[4:0])})
        else $error("month digits not stored");

    day_reserved_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        readAckSeq
        and rdmac_pkg::regHit(wb_adr_i, rdmac_pkg::DAY_ALARM_OFF)
        |-> wb_dat_o[6] == 1'b0)
        else $error("day bit 6 not zero");

    month_reserved_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        readAckSeq
        and rdmac_pkg::regHit(wb_adr_i, rdmac_pkg::MONTH_ALARM_OFF)
        |-> wb_dat_o[6:5] == 2'b00)
        else $error("month bits 5 and 6 not zero");

    flag_clear_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        ctrlWr && !wrByte[0] && !matchNow |=> !alarmFlag)
        else $error("flag not cleared by writing 0");

    set_wins_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        matchNow |=> alarmFlag ##0 (alarmFlag [*1]))
        else $error("match lost against clear");

    irq_raise_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        matchNow && state.aie && state.irqMask && !manualReset
        && !maskWr |=> irq)
        else $error("interrupt not raised");

    ack_pulse_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    ack_answer_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        busReq && !wb_ack_o && !manualReset |=> wb_ack_o)
        else $error("request not answered next cycle");

    sequence flagWriteOneSeq;
        ctrlWr && wrByte[rdmac_pkg::ALARM_FLAG_BIT];
    endsequence

    flag_write_one_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        flagWriteOneSeq and alarmFlag |=> alarmFlag)
        else $error("writing 1 disturbed the flag");

    // Flag moves only on a match or a control write
    flag_hold_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        !matchNow && !ctrlWr |=> $stable(alarmFlag))
        else $error("flag changed with no cause");

    aie_reset_a: assert property (@(posedge sys_clk)
        reset || manualReset |=> !state.aie)
        else $error("aie not cleared by reset");

    // Enables belong to power-on reset only
    manual_keeps_a: assert property (@(posedge sys_clk)
        disable iff (reset)
        manualReset && !dayWr && !monthWr |=>
        dayEnable == $past(dayEnable) && monthEnable == $past(monthEnable))
        else $error("enable changed by manual reset");

endmodule : rdmac_top
`default_nettype wire

//--- tb/rdmac_top_tb.sv
// Self-checking bench of the day/month alarm compare block
`timescale 1ns/10ps
`default_nettype none
module rdmac_top_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        sys_clk;
    logic        reset;
    logic        manualReset;
    logic [7:0]  wbAdr;
    logic [31:0] wbDatW;
    logic [3:0]  wbSel;
    logic        wbWe;
    logic        wbCyc;
    logic        wbStb;
    logic [31:0] wbDatR;
    logic        wbAck;
    logic [5:0]  dayCounter;
    logic [4:0]  monthCounter;
    logic        counterUpdate;
    logic [3:0]  otherEnable;
    logic [3:0]  otherMatch;
    logic        alarmFlag;
    logic        irq;
    int          mismatches;
    int          checks_done;
    int          cycles;
    int          mi;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [5:0]  dv;
    logic [5:0]  mv;
    logic [5:0]  dc;
    logic [5:0]  t;
    logic [4:0]  mc;
    logic        dEn;
    logic        mEn;
    logic [3:0]  oe;
    logic [3:0]  om;

    rdmac_top u_dut (
        .sys_clk       (sys_clk),
        .reset         (reset),
        .manualReset   (manualReset),
        .wb_adr_i      (wbAdr),
        .wb_dat_i      (wbDatW),
        .wb_sel_i      (wbSel),
        .wb_we_i       (wbWe),
        .wb_cyc_i      (wbCyc),
        .wb_stb_i      (wbStb),
        .wb_dat_o      (wbDatR),
        .wb_ack_o      (wbAck),
        .dayCounter    (dayCounter),
        .monthCounter  (monthCounter),
        .counterUpdate (counterUpdate),
        .otherEnable   (otherEnable),
        .otherMatch    (otherMatch),
        .alarmFlag     (alarmFlag),
        .irq           (irq)
    );

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Whole run needs about 1100 cycles; generous ceiling
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    function automatic logic [5:0] toBcd(input int n);
        return 6'(((n / 10) << 4) + (n % 10));
    endfunction : toBcd

    // Longest day of each month; February allows the leap day
    function automatic int monthDays(input int m);
        if (m == 2) return 29;
        if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
        return 31;
    endfunction : monthDays

    // Flag expected only with at least one enable and all enabled equal
    function automatic logic expMatch(input logic de, input logic [5:0] a,
                                      input logic [5:0] b, input logic me,
                                      input logic [4:0] c,
                                      input logic [4:0] d,
                                      input logic [3:0] e,
                                      input logic [3:0] f);
        return (de || me || (e != 4'h0)) && (!de || a == b)
            && (!me || c == d) && ((e & ~f) == 4'h0);
    endfunction : expMatch

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask : check

    // Classic single cycle; held until ack is sampled high
    task automatic wbXfer(input logic we, input logic [7:0] adr,
                          input logic [31:0] dat, input logic [3:0] sel,
                          output logic [31:0] rdata);
        @(posedge sys_clk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= adr;
        wbDatW <= dat;
        wbSel  <= sel;
        do @(posedge sys_clk); while (wbAck !== 1'b1);
        rdata = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
    endtask : wbXfer

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] junk;
        wbXfer(1'b1, adr, dat, 4'h1, junk);
        repeat (2) @(posedge sys_clk);
    endtask : wr

    task automatic rdm(input logic [7:0] adr, input logic [31:0] mask,
                       input logic [31:0] exp);
        logic [31:0] r;
        wbXfer(1'b0, adr, 32'h0, 4'hf, r);
        check(r & mask, exp, "register read");
    endtask : rdm

    task automatic pulse(input logic [5:0] d, input logic [4:0] m);
        @(posedge sys_clk);
        dayCounter    <= d;
        monthCounter  <= m;
        counterUpdate <= 1'b1;
        @(posedge sys_clk);
        counterUpdate <= 1'b0;
        @(posedge sys_clk);
    endtask : pulse

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {manualReset, wbCyc, wbStb, wbWe, counterUpdate} = 5'h00;
        {wbAdr, wbDatW, wbSel} = 44'h0;
        {dayCounter, monthCounter, otherEnable, otherMatch} = 19'h0;
        {mismatches, checks_done, cycles} = 96'h0;
        reset = 1'b1;
        seed  = 32'hd0461faf;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        rdm(rdmac_pkg::DAY_ALARM_OFF, 32'hffffffc0, 32'h0);
        rdm(rdmac_pkg::MONTH_ALARM_OFF, 32'hffffffe0, 32'h0);
        rdm(rdmac_pkg::CONTROL_OFF, 32'h09, 32'h0);
        wr(8'h80, 32'hffffffff);
        rdm(8'h80, 32'hffffffff, 32'h0);
        pulse(6'h00, 5'h00);
        check(32'(alarmFlag), 32'h0, "flag with nothing enabled");
        // Random values, reserved bits written with random seed bits on purpose
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            mi  = 1 + int'((seed >> 8) % 12);
            mv  = toBcd(mi);
            dv  = toBcd(1 + int'(seed % monthDays(mi)));
            dEn = seed[20];
            mEn = seed[21];
            oe  = seed[27:24];
            om  = seed[12] ? 4'hf : seed[31:28];
            wr(rdmac_pkg::DAY_ALARM_OFF, {24'h0, dEn, seed[22], dv});
            wr(rdmac_pkg::MONTH_ALARM_OFF, {24'h0, mEn, seed[23:22], mv[4:0]});
            rdm(rdmac_pkg::DAY_ALARM_OFF, 32'hffffffff,
                {24'h0, dEn, 1'b0, dv});
            rdm(rdmac_pkg::MONTH_ALARM_OFF, 32'hffffffff,
                {24'h0, mEn, 2'b00, mv[4:0]});
            wr(rdmac_pkg::CONTROL_OFF, 32'h0);
            seed = xs(seed);
            t  = toBcd(1 + int'(seed % 31));
            dc = seed[13] ? dv : t;
            t  = toBcd(1 + int'((seed >> 8) % 12));
            mc = seed[14] ? mv[4:0] : t[4:0];
            otherEnable <= oe;
            otherMatch  <= om;
            pulse(dc, mc);
            check(32'(alarmFlag), 32'(expMatch(dEn, dv, dc, mEn, mv[4:0], mc,
                  oe, om)), "alarm flag");
        end
        // Flag write semantics
        otherEnable <= 4'h0;
        wr(rdmac_pkg::DAY_ALARM_OFF, 32'h95);
        wr(rdmac_pkg::MONTH_ALARM_OFF, 32'h12);
        pulse(6'h15, 5'h09);
        check(32'(alarmFlag), 32'h1, "day-only match");
        wr(rdmac_pkg::CONTROL_OFF, 32'h1);
        rdm(rdmac_pkg::CONTROL_OFF, 32'h09, 32'h1);
        wr(rdmac_pkg::CONTROL_OFF, 32'h0);
        check(32'(alarmFlag), 32'h0, "flag cleared by zero");
        // Interrupt raise, mask, clear
        wr(rdmac_pkg::IRQ_MASK_OFF, 32'h1);
        wr(rdmac_pkg::CONTROL_OFF, 32'h8);
        pulse(6'h15, 5'h09);
        repeat (2) @(posedge sys_clk);
        check(32'(irq), 32'h1, "irq raised");
        rdm(rdmac_pkg::IRQ_STATUS_OFF, 32'h1, 32'h1);
        wr(rdmac_pkg::IRQ_MASK_OFF, 32'h0);
        check(32'(irq), 32'h0, "irq masked");
        wr(rdmac_pkg::IRQ_MASK_OFF, 32'h1);
        check(32'(irq), 32'h1, "irq unmasked");
        wr(rdmac_pkg::IRQ_STATUS_OFF, 32'h1);
        check(32'(irq), 32'h0, "irq cleared");
        // Write with lane 0 deselected must not land
        wbXfer(1'b1, rdmac_pkg::DAY_ALARM_OFF, 32'h0, 4'he, rd);
        rdm(rdmac_pkg::DAY_ALARM_OFF, 32'hff, 32'h95);
        wr(rdmac_pkg::MONTH_ALARM_OFF, 32'h92);
        // Manual reset: only aie drops
        @(posedge sys_clk);
        manualReset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        manualReset <= 1'b0;
        rdm(rdmac_pkg::CONTROL_OFF, 32'h09, 32'h1);
        rdm(rdmac_pkg::DAY_ALARM_OFF, 32'hff, 32'h95);
        rdm(rdmac_pkg::MONTH_ALARM_OFF, 32'hff, 32'h92);
        // Power-on reset mid-run: enables drop, values stay
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rdm(rdmac_pkg::DAY_ALARM_OFF, 32'hff, 32'h15);
        rdm(rdmac_pkg::MONTH_ALARM_OFF, 32'hff, 32'h12);
        rdm(rdmac_pkg::CONTROL_OFF, 32'h09, 32'h0);
        end_of_test();
    end
endmodule : rdmac_top_tb
`default_nettype wire
